//--- logic/cfr_core.sv
// What this block does
// - All state held while clock stopped
// - No minimum clock rate, fully static
// - Eight 16-bit registers, four split bytes
// - Four 16-bit segment registers
// - Instruction pointer holds next offset
// - 16-bit flags word, result and control
// - Bit 0 carry or borrow from msb
// - Bit 2 even parity of low byte
// - Bit 4 carry from low nibble
// - Bit 6 set on zero result
// - Bit 7 copies result msb
// - Bit 11 signed overflow
// - Bit 8 traps after next instruction, clears
// - Bit 9 gates maskable interrupts
// - Bit 10 chooses string decrement or increment
// - Hold acknowledge low only while hold low
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_core
  import cfr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        instr_done,
  input  wire logic        intr_req,
  input  wire logic [7:0]  intr_vector,
  input  wire logic        string_step,
  input  wire logic        string_word,
  input  wire logic        hold_req,
  output logic             hold_acknowledge,
  output logic             step_trap,
  output logic             int_accept,
  output logic      [7:0]  int_vector
);

  cfr_core_if cif ();

  cfr_alu u_alu (
    .bus (cif.alu)
  );

  cfr_regs u_regs (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bus     (cif.regs)
  );

  // Bus address phase capture
  logic        dp_write_reg;
  logic        dp_read_reg;
  logic [7:0]  dp_addr_reg;
  logic        ap_valid;

  assign ap_valid  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_read_reg  <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else begin
      dp_write_reg <= ap_valid && hwrite;
      dp_read_reg  <= ap_valid && !hwrite;
      dp_addr_reg  <= ap_valid ? haddr[7:0] : dp_addr_reg;
    end
  end

  // Address decode
  logic       hit_flags;
  logic       hit_ctrl;
  logic       hit_opb;
  logic       hit_result;
  logic       hit_ip;
  logic       hit_status;
  logic       hit_vector;
  logic       hit_gpr;
  logic       hit_seg;
  logic       hit_half;
  logic [2:0] dp_idx;

  assign dp_idx     = dp_addr_reg[4:2];
  assign hit_flags  = dp_addr_reg == `CFR_OFF_FLAGS;
  assign hit_ctrl   = dp_addr_reg == `CFR_OFF_CTRL;
  assign hit_opb    = dp_addr_reg == `CFR_OFF_OPB;
  assign hit_result = dp_addr_reg == `CFR_OFF_RESULT;
  assign hit_ip     = dp_addr_reg == `CFR_OFF_IP;
  assign hit_status = dp_addr_reg == `CFR_OFF_STATUS;
  assign hit_vector = dp_addr_reg == `CFR_OFF_VECTOR;
  // Window compare on the upper bits, word alignment on the lower two
  assign hit_gpr    = (dp_addr_reg & 8'hE3) == `CFR_OFF_GPR;
  assign hit_seg    = (dp_addr_reg & 8'hF3) == `CFR_OFF_SEG;
  assign hit_half   = (dp_addr_reg & 8'hE3) == `CFR_OFF_HALF;

  // Control word fields, taken in the write data phase
  logic         ctrl_wr;
  logic         alu_go;
  logic         alu_byte;
  logic [2:0]   alu_dst;
  cfr_alu_op_t  alu_op;
  cfr_flag_op_t flag_op;

  assign ctrl_wr  = dp_write_reg && hit_ctrl;
  assign alu_go   = ctrl_wr && hwdata[`CFR_CTL_GO];
  assign alu_byte = hwdata[`CFR_CTL_BYTE];
  assign alu_dst  = hwdata[`CFR_CTL_DST_LSB +: 3];
  assign alu_op   = cfr_alu_op_t'(hwdata[`CFR_CTL_OP_LSB +: 3]);
  assign flag_op  = ctrl_wr ? cfr_flag_op_t'(hwdata[`CFR_CTL_FOP_LSB +: 3]) : CFR_FOP_NONE;

  cfr_word_t flags_reg;
  cfr_word_t flags_next;
  cfr_word_t opb_reg;
  cfr_word_t result_reg;
  cfr_word_t dst_word;

  // Byte destination codes 0..3 pick low halves, 4..7 the high halves
  assign dst_word      = cif.gpr[alu_byte ? {1'b0, alu_dst[1:0]} : alu_dst];
  assign cif.op        = alu_op;
  assign cif.byte_mode = alu_byte;
  assign cif.a         = alu_byte ? (alu_dst[2] ? {8'h00, dst_word[15:8]}
                                                : {8'h00, dst_word[7:0]}) : dst_word;
  assign cif.b         = alu_byte ? {8'h00, opb_reg[7:0]} : opb_reg;
  assign cif.cin       = flags_reg[`CFR_BIT_CF];

  // Register file write: bus store or arithmetic writeback
  logic        bus_rf_wr;
  logic        alu_wb;
  cfr_wr_sel_t bus_sel;
  logic [2:0]  bus_idx;

  assign bus_rf_wr = dp_write_reg && (hit_gpr || hit_seg || hit_half || hit_ip);
  assign alu_wb    = alu_go && (alu_op != CFR_OP_CMP);
  assign bus_idx   = hit_half ? {1'b0, dp_idx[1:0]} : dp_idx;
  assign bus_sel   = hit_gpr ? CFR_WR_WORD :
                     hit_seg ? CFR_WR_SEG :
                     hit_ip  ? CFR_WR_IP :
                     dp_idx[2] ? CFR_WR_HI : CFR_WR_LO;

  assign cif.wr_en    = bus_rf_wr || alu_wb;
  assign cif.wr_sel   = bus_rf_wr ? bus_sel :
                        (alu_byte ? (alu_dst[2] ? CFR_WR_HI : CFR_WR_LO) : CFR_WR_WORD);
  assign cif.wr_idx   = bus_rf_wr ? bus_idx : alu_dst;
  assign cif.wr_data  = bus_rf_wr ? hwdata[15:0] : cif.result;
  assign cif.str_step = string_step;
  assign cif.str_word = string_word;
  assign cif.str_dir  = flags_reg[`CFR_BIT_DF];

  // Instruction boundary and exception sequencing
  logic   boundary;
  logic   take_step;
  logic   take_int;
  logic   step_trap_reg;
  logic   int_accept_reg;
  logic [7:0] int_vector_reg;

  assign boundary  = instr_done || alu_go;
  assign take_step = boundary && flags_reg[`CFR_BIT_TF];
  assign take_int  = boundary && !take_step && intr_req && flags_reg[`CFR_BIT_IF];

  always_comb begin
    flags_next = flags_reg;
    if (dp_write_reg && hit_flags) begin
      flags_next = hwdata[15:0];
    end
    if (alu_go) begin
      flags_next = (flags_next & ~`CFR_FLAGS_ARITH) |
                   (cif.res_flags & `CFR_FLAGS_ARITH);
    end
    case (flag_op)
      CFR_FOP_STC: flags_next[`CFR_BIT_CF] = 1'b1;
      CFR_FOP_CLC: flags_next[`CFR_BIT_CF] = 1'b0;
      CFR_FOP_CMC: flags_next[`CFR_BIT_CF] = !flags_next[`CFR_BIT_CF];
      CFR_FOP_STD: flags_next[`CFR_BIT_DF] = 1'b1;
      CFR_FOP_CLD: flags_next[`CFR_BIT_DF] = 1'b0;
      CFR_FOP_STI: flags_next[`CFR_BIT_IF] = 1'b1;
      CFR_FOP_CLI: flags_next[`CFR_BIT_IF] = 1'b0;
      default:     flags_next = flags_next;
    endcase
    if (take_step) begin
      flags_next[`CFR_BIT_TF] = 1'b0;
    end
    flags_next = (flags_next & ~`CFR_FLAGS_FIXMSK) | `CFR_FLAGS_FIXVAL;
  end

  // Pure edge-triggered state with no refresh or timeouts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg  <= `CFR_FLAGS_RESET;
      opb_reg    <= `CFR_WORD_RESET;
      result_reg <= `CFR_WORD_RESET;
    end else begin
      flags_reg  <= flags_next;
      opb_reg    <= (dp_write_reg && hit_opb) ? hwdata[15:0] : opb_reg;
      result_reg <= alu_go ? cif.result : result_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_trap_reg  <= 1'b0;
      int_accept_reg <= 1'b0;
      int_vector_reg <= 8'h00;
    end else begin
      step_trap_reg  <= take_step;
      int_accept_reg <= take_int;
      int_vector_reg <= take_int ? intr_vector : int_vector_reg;
    end
  end

  assign step_trap  = step_trap_reg;
  assign int_accept = int_accept_reg;
  assign int_vector = int_vector_reg;

  // Hold acknowledge rises with the request and drops one cycle after the request falls
  logic hold_seen_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_seen_reg <= 1'b0;
    end else begin
      hold_seen_reg <= hold_req;
    end
  end

  assign hold_acknowledge = hold_req || hold_seen_reg;

  // Read data mux
  cfr_word_t rd_word;
  cfr_word_t half_src;

  assign half_src = cif.gpr[{1'b0, dp_idx[1:0]}];

  always_comb begin
    rd_word = 16'h0000;
    if (hit_flags) begin
      rd_word = flags_reg;
    end else if (hit_ctrl) begin
      rd_word = 16'h0000;
    end else if (hit_opb) begin
      rd_word = opb_reg;
    end else if (hit_result) begin
      rd_word = result_reg;
    end else if (hit_ip) begin
      rd_word = cif.ip;
    end else if (hit_status) begin
      rd_word = {13'h0000, int_accept_reg, step_trap_reg, hold_acknowledge};
    end else if (hit_vector) begin
      rd_word = {8'h00, int_vector_reg};
    end else if (hit_gpr) begin
      rd_word = cif.gpr[dp_idx];
    end else if (hit_seg) begin
      rd_word = cif.seg[dp_idx[1:0]];
    end else if (hit_half) begin
      rd_word = dp_idx[2] ? {8'h00, half_src[15:8]} : {8'h00, half_src[7:0]};
    end
  end

  assign hrdata = dp_read_reg ? {16'h0000, rd_word} : 32'h0000_0000;

endmodule : cfr_core

//--- logic/cfr_cfg.svh
`ifndef CFR_CFG_SVH
`define CFR_CFG_SVH

// Register byte offsets
`define CFR_OFF_FLAGS    8'h00
`define CFR_OFF_CTRL     8'h04
`define CFR_OFF_OPB      8'h08
`define CFR_OFF_RESULT   8'h0C
`define CFR_OFF_IP       8'h10
`define CFR_OFF_STATUS   8'h14
`define CFR_OFF_VECTOR   8'h18
`define CFR_OFF_GPR      8'h20
`define CFR_OFF_SEG      8'h40
`define CFR_OFF_HALF     8'h60

// Flags word bit positions
`define CFR_BIT_CF       0
`define CFR_BIT_PF       2
`define CFR_BIT_AF       4
`define CFR_BIT_ZF       6
`define CFR_BIT_SF       7
`define CFR_BIT_TF       8
`define CFR_BIT_IF       9
`define CFR_BIT_DF       10
`define CFR_BIT_OF       11

// Flags word constants
`define CFR_FLAGS_RESET  16'h0002
`define CFR_FLAGS_FIXMSK 16'hF02A
`define CFR_FLAGS_FIXVAL 16'h0002
`define CFR_FLAGS_ARITH  16'h08D5

// Control register fields
`define CFR_CTL_OP_LSB   0
`define CFR_CTL_BYTE     3
`define CFR_CTL_DST_LSB  4
`define CFR_CTL_GO       7
`define CFR_CTL_FOP_LSB  8

// Register reset values
`define CFR_WORD_RESET   16'h0000

`endif

//--- logic/cfr_pkg.sv
package cfr_pkg;

  typedef logic [15:0] cfr_word_t;

  typedef enum logic [2:0] {
    CFR_OP_ADD = 3'b000,
    CFR_OP_ADC = 3'b001,
    CFR_OP_SUB = 3'b010,
    CFR_OP_SBB = 3'b011,
    CFR_OP_AND = 3'b100,
    CFR_OP_OR  = 3'b101,
    CFR_OP_XOR = 3'b110,
    CFR_OP_CMP = 3'b111
  } cfr_alu_op_t;

  typedef enum logic [2:0] {
    CFR_WR_WORD = 3'b000,
    CFR_WR_LO   = 3'b001,
    CFR_WR_HI   = 3'b010,
    CFR_WR_SEG  = 3'b011,
    CFR_WR_IP   = 3'b100
  } cfr_wr_sel_t;

  typedef enum logic [2:0] {
    CFR_FOP_NONE = 3'b000,
    CFR_FOP_STC  = 3'b001,
    CFR_FOP_CLC  = 3'b010,
    CFR_FOP_CMC  = 3'b011,
    CFR_FOP_STD  = 3'b100,
    CFR_FOP_CLD  = 3'b101,
    CFR_FOP_STI  = 3'b110,
    CFR_FOP_CLI  = 3'b111
  } cfr_flag_op_t;

endpackage : cfr_pkg

//--- logic/cfr_core_if.sv
`timescale 1ns/1ps
interface cfr_core_if;
  import cfr_pkg::*;

  cfr_alu_op_t       op;
  logic              byte_mode;
  cfr_word_t         a;
  cfr_word_t         b;
  logic              cin;
  cfr_word_t         result;
  cfr_word_t         res_flags;

  logic              wr_en;
  cfr_wr_sel_t       wr_sel;
  logic [2:0]        wr_idx;
  cfr_word_t         wr_data;
  logic              str_step;
  logic              str_word;
  logic              str_dir;
  logic [7:0][15:0]  gpr;
  logic [3:0][15:0]  seg;
  cfr_word_t         ip;

  modport alu  (input op, byte_mode, a, b, cin, output result, res_flags);
  modport regs (input wr_en, wr_sel, wr_idx, wr_data, str_step, str_word, str_dir,
                output gpr, seg, ip);
  modport core (output op, byte_mode, a, b, cin, wr_en, wr_sel, wr_idx, wr_data,
                str_step, str_word, str_dir,
                input result, res_flags, gpr, seg, ip);
endinterface : cfr_core_if

//--- logic/cfr_alu.sv
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_alu
  import cfr_pkg::*;
(
  cfr_core_if.alu  bus
);

  logic        is_sub;
  logic        is_logic;
  logic        cc;
  cfr_word_t   bw;
  logic [16:0] sum17;
  logic [8:0]  sum9;
  cfr_word_t   res;
  logic        cout;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;

  assign is_sub   = (bus.op == CFR_OP_SUB) || (bus.op == CFR_OP_SBB) || (bus.op == CFR_OP_CMP);
  assign is_logic = (bus.op == CFR_OP_AND) || (bus.op == CFR_OP_OR) || (bus.op == CFR_OP_XOR);
  assign cc       = ((bus.op == CFR_OP_ADC) || (bus.op == CFR_OP_SBB)) ? bus.cin : 1'b0;
  // Subtract as add of the complement; borrow is the inverted carry
  assign bw       = is_sub ? ~bus.b : bus.b;
  assign sum17    = {1'b0, bus.a} + {1'b0, bw} + {16'h0000, is_sub ^ cc};
  assign sum9     = {1'b0, bus.a[7:0]} + {1'b0, bw[7:0]} + {8'h00, is_sub ^ cc};

  always_comb begin
    case (bus.op)
      CFR_OP_AND: res = bus.a & bus.b;
      CFR_OP_OR:  res = bus.a | bus.b;
      CFR_OP_XOR: res = bus.a ^ bus.b;
      default:    res = bus.byte_mode ? {8'h00, sum9[7:0]} : sum17[15:0];
    endcase
    if (bus.byte_mode) begin
      res = {8'h00, res[7:0]};
    end
  end

  assign cout  = bus.byte_mode ? sum9[8] : sum17[16];
  assign msb_a = bus.byte_mode ? bus.a[7] : bus.a[15];
  assign msb_b = bus.byte_mode ? bw[7] : bw[15];
  assign msb_r = bus.byte_mode ? res[7] : res[15];
  assign bus.result = res;

  always_comb begin
    bus.res_flags = 16'h0000;
    bus.res_flags[`CFR_BIT_CF] = !is_logic && (cout ^ is_sub);
    bus.res_flags[`CFR_BIT_PF] = ~^res[7:0];
    bus.res_flags[`CFR_BIT_AF] = !is_logic && (bus.a[4] ^ bus.b[4] ^ res[4]);
    bus.res_flags[`CFR_BIT_ZF] = bus.byte_mode ? (res[7:0] == 8'h00)
                                               : (res == 16'h0000);
    bus.res_flags[`CFR_BIT_SF] = msb_r;
    bus.res_flags[`CFR_BIT_OF] = !is_logic && (msb_a == msb_b) && (msb_r != msb_a);
  end

endmodule : cfr_alu

//--- logic/cfr_regs.sv
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_regs
  import cfr_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  cfr_core_if.regs   bus
);

  logic [7:0][15:0] gpr_reg;
  logic [3:0][15:0] seg_reg;
  cfr_word_t        ip_reg;
  cfr_word_t        str_delta;

  assign str_delta = bus.str_word ? 16'h0002 : 16'h0001;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gpr
      logic wr_word;
      logic wr_lo;
      logic wr_hi;
      logic str_hit;
      assign wr_word = bus.wr_en && (bus.wr_sel == CFR_WR_WORD) && (bus.wr_idx == 3'(gi));
      assign wr_lo   = bus.wr_en && (bus.wr_sel == CFR_WR_LO) && (gi < 4) &&
                       (bus.wr_idx[1:0] == 2'(gi));
      assign wr_hi   = bus.wr_en && (bus.wr_sel == CFR_WR_HI) && (gi < 4) &&
                       (bus.wr_idx[1:0] == 2'(gi));
      assign str_hit = bus.str_step && (gi >= 6);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gpr_reg[gi] <= `CFR_WORD_RESET;
        end else if (wr_word) begin
          gpr_reg[gi] <= bus.wr_data;
        end else if (wr_lo) begin
          gpr_reg[gi][7:0] <= bus.wr_data[7:0];
        end else if (wr_hi) begin
          gpr_reg[gi][15:8] <= bus.wr_data[7:0];
        end else if (str_hit) begin
          gpr_reg[gi] <= bus.str_dir ? gpr_reg[gi] - str_delta
                                     : gpr_reg[gi] + str_delta;
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_seg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          seg_reg[gi] <= `CFR_WORD_RESET;
        end else if (bus.wr_en && (bus.wr_sel == CFR_WR_SEG) &&
                     (bus.wr_idx[1:0] == 2'(gi))) begin
          seg_reg[gi] <= bus.wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ip_reg <= `CFR_WORD_RESET;
    end else if (bus.wr_en && (bus.wr_sel == CFR_WR_IP)) begin
      ip_reg <= bus.wr_data;
    end
  end

  assign bus.gpr = gpr_reg;
  assign bus.seg = seg_reg;
  assign bus.ip  = ip_reg;

endmodule : cfr_regs

//--- tb/cfr_core_checker.sv
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module cfr_core_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        instr_done,
  input wire logic        intr_req,
  input wire logic [7:0]  intr_vector,
  input wire logic        string_step,
  input wire logic        string_word,
  input wire logic        hold_req,
  input wire logic        hold_acknowledge,
  input wire logic        step_trap,
  input wire logic        int_accept,
  input wire logic [7:0]  int_vector
);
  logic       rd_dp_reg;
  logic       wr_dp_reg;
  logic [7:0] dp_addr_reg;
  wire        take     = hsel && hready && htrans[1];
  wire        boundary = instr_done ||
                         (wr_dp_reg && dp_addr_reg == `CFR_OFF_CTRL && hwdata[`CFR_CTL_GO]);
  // Tracks the data phase of each transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp_reg   <= 1'b0;
      wr_dp_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else if (hready) begin
      rd_dp_reg   <= take && !hwrite;
      wr_dp_reg   <= take && hwrite;
      dp_addr_reg <= haddr[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  hold_follow_a: assert property (hold_req |-> hold_acknowledge)
    else $error("hold ack low while hold request high");
  hold_drop_a: assert property (!hold_req && !$past(hold_req) |-> !hold_acknowledge)
    else $error("hold ack stays high after release");
  trap_cause_a: assert property (step_trap |-> $past(boundary))
    else $error("step trap without instruction boundary");
  trap_pulse_a: assert property (step_trap |=> !step_trap)
    else $error("step trap longer than one cycle");
  int_cause_a: assert property (int_accept |-> $past(boundary && intr_req) && !step_trap)
    else $error("interrupt accepted without request at boundary");
  int_vec_a: assert property (int_accept |-> int_vector == $past(intr_vector))
    else $error("interrupt vector not latched");
  idle_rdata_a: assert property (!rd_dp_reg |-> hrdata == 32'h0000_0000)
    else $error("read data outside read data phase");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  flags_fixed_a: assert property (rd_dp_reg && dp_addr_reg == `CFR_OFF_FLAGS |->
    (hrdata[15:0] & `CFR_FLAGS_FIXMSK) == `CFR_FLAGS_FIXVAL)
    else $error("undefined flag bits not fixed");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  trap_seen_c: cover property (step_trap);
  int_seen_c: cover property (int_accept);
  hold_seen_c: cover property ($fell(hold_req));
endmodule : cfr_core_checker

bind cfr_core cfr_core_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .instr_done(instr_done), .intr_req(intr_req), .intr_vector(intr_vector),
  .string_step(string_step), .string_word(string_word), .hold_req(hold_req),
  .hold_acknowledge(hold_acknowledge), .step_trap(step_trap), .int_accept(int_accept),
  .int_vector(int_vector));

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "cfr_cfg.svh"
module tb_top
  import cfr_pkg::*;
;
  typedef struct {cfr_alu_op_t op; logic bm; logic [15:0] fl, a, b, res, ef;} cfr_alu_case_t;
  typedef struct {cfr_flag_op_t fop; logic [15:0] init, exp;} cfr_fop_case_t;
  logic        hclk, hresetn, hsel, hwrite, instr_done, intr_req, clk_run;
  logic        string_step, string_word, hold_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  intr_vector, int_vector;
  logic        hreadyout, hresp, hold_acknowledge, step_trap, int_accept;
  wire         hready = hreadyout;
  int          n_errors, checks_done, cycles;
  cfr_alu_case_t ac[10] = '{
    '{CFR_OP_ADD, 1'b0, 16'h0000, 16'hFFFF, 16'h0001, 16'h0000, 16'h0055},
    '{CFR_OP_ADD, 1'b0, 16'h0000, 16'h7FFF, 16'h0001, 16'h8000, 16'h0894},
    '{CFR_OP_ADC, 1'b0, 16'h0001, 16'h0001, 16'h0001, 16'h0003, 16'h0004},
    '{CFR_OP_SUB, 1'b0, 16'h0000, 16'h0000, 16'h0001, 16'hFFFF, 16'h0095},
    '{CFR_OP_SBB, 1'b0, 16'h0001, 16'h0005, 16'h0002, 16'h0002, 16'h0000},
    '{CFR_OP_SUB, 1'b1, 16'h0000, 16'h0080, 16'h0001, 16'h007F, 16'h0810},
    '{CFR_OP_AND, 1'b0, 16'h0000, 16'hF0F0, 16'h0F0F, 16'h0000, 16'h0044},
    '{CFR_OP_OR,  1'b0, 16'h0801, 16'h8000, 16'h0001, 16'h8001, 16'h0080},
    '{CFR_OP_XOR, 1'b0, 16'h0010, 16'h00FF, 16'h0001, 16'h00FE, 16'h0000},
    '{CFR_OP_CMP, 1'b0, 16'h0000, 16'h0005, 16'h0005, 16'h0005, 16'h0044}};
  cfr_fop_case_t fc[7] = '{'{CFR_FOP_STC, 16'h0000, 16'h0003},
    '{CFR_FOP_CLC, 16'h0001, 16'h0002}, '{CFR_FOP_CMC, 16'h0001, 16'h0002},
    '{CFR_FOP_STD, 16'h0000, 16'h0402}, '{CFR_FOP_CLD, 16'h0400, 16'h0002},
    '{CFR_FOP_STI, 16'h0000, 16'h0202}, '{CFR_FOP_CLI, 16'h0200, 16'h0002}};

  cfr_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .instr_done(instr_done), .intr_req(intr_req),
    .intr_vector(intr_vector), .string_step(string_step), .string_word(string_word),
    .hold_req(hold_req), .hold_acknowledge(hold_acknowledge), .step_trap(step_trap),
    .int_accept(int_accept), .int_vector(int_vector));

  initial forever #12.5 if (clk_run) hclk = ~hclk;

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [15:0] d);
    ahb(1'b1, a, {16'h0000, d});
  endtask : wr

  task rchk(input string w, input logic [7:0] a, input logic [15:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(w, {16'h0000, e}, rd);
  endtask : rchk

  task boundary(input logic et, input logic ei);
    instr_done <= 1'b1;
    @(posedge hclk);
    instr_done <= 1'b0;
    #1 chk("step_trap", {31'h0, et}, {31'h0, step_trap});
    chk("int_accept", {31'h0, ei}, {31'h0, int_accept});
    @(posedge hclk);
    #1 chk("pulse_end", 32'h0, {30'h0, step_trap, int_accept});
    @(posedge hclk);
  endtask : boundary

  task t_regs;
    for (int n = 0; n < 8; n++) wr(`CFR_OFF_GPR + 8'(4 * n), 16'h1111 * 16'(n + 1));
    for (int n = 0; n < 8; n++) rchk("gpr", `CFR_OFF_GPR + 8'(4 * n), 16'h1111 * 16'(n + 1));
    for (int n = 0; n < 4; n++) wr(`CFR_OFF_SEG + 8'(4 * n), 16'hC000 + 16'(n));
    for (int n = 0; n < 4; n++) rchk("seg", `CFR_OFF_SEG + 8'(4 * n), 16'hC000 + 16'(n));
    wr(`CFR_OFF_IP, 16'h1234);
    rchk("ip", `CFR_OFF_IP, 16'h1234);
    wr(`CFR_OFF_GPR, 16'h0000);
    wr(`CFR_OFF_HALF + 8'h10, 16'h00AB);
    wr(`CFR_OFF_HALF, 16'h00CD);
    rchk("halves", `CFR_OFF_GPR, 16'hABCD);
    rchk("high_half", `CFR_OFF_HALF + 8'h10, 16'h00AB);
    rchk("unmapped", 8'h80, 16'h0000);
    rchk("ctrl_read", `CFR_OFF_CTRL, 16'h0000);
    wr(`CFR_OFF_FLAGS, 16'hFFFF);
    rchk("flags_fixed", `CFR_OFF_FLAGS, (16'hFFFF & ~`CFR_FLAGS_FIXMSK) | `CFR_FLAGS_FIXVAL);
    $display("register test done");
  endtask : t_regs

  task t_alu;
    logic [15:0] m;
    for (int i = 0; i < 10; i++) begin
      m = ac[i].bm ? 16'h00FF : 16'hFFFF;
      wr(`CFR_OFF_FLAGS, ac[i].fl);
      wr(`CFR_OFF_GPR, ac[i].a);
      wr(`CFR_OFF_OPB, ac[i].b);
      ahb(1'b1, `CFR_OFF_CTRL, {16'h0000, 8'h00, 1'b1, 3'h0, ac[i].bm, ac[i].op});
      ahb(1'b0, `CFR_OFF_RESULT, 32'h0000_0000);
      if (ac[i].op != CFR_OP_CMP) chk("result", {16'h0, ac[i].res & m}, rd & {16'h0, m});
      ahb(1'b0, `CFR_OFF_FLAGS, 32'h0000_0000);
      chk("flags", {16'h0, ac[i].ef}, rd & {16'h0, `CFR_FLAGS_ARITH});
      rchk("dest", `CFR_OFF_GPR, ac[i].res);
    end
    wr(`CFR_OFF_FLAGS, 16'h0000);
    wr(`CFR_OFF_GPR, 16'h7F05);
    wr(`CFR_OFF_OPB, 16'h0001);
    wr(`CFR_OFF_CTRL, 16'h00C8);
    rchk("hi_byte_dest", `CFR_OFF_GPR, 16'h8005);
    rchk("hi_byte_flags", `CFR_OFF_FLAGS, 16'h0892);
    for (int i = 0; i < 7; i++) begin
      wr(`CFR_OFF_FLAGS, fc[i].init);
      ahb(1'b1, `CFR_OFF_CTRL, {16'h0000, 5'h00, fc[i].fop, 8'h00});
      rchk("flag_op", `CFR_OFF_FLAGS, fc[i].exp);
    end
    $display("alu test done");
  endtask : t_alu

  task t_events;
    wr(`CFR_OFF_FLAGS, 16'h0100);
    boundary(1'b1, 1'b0);
    rchk("trap_clears", `CFR_OFF_FLAGS, 16'h0002);
    boundary(1'b0, 1'b0);
    wr(`CFR_OFF_FLAGS, 16'h0100);
    ahb(1'b1, `CFR_OFF_CTRL, 32'h0000_0080);
    #1 chk("ctrl_trap", 32'h1, {31'h0, step_trap});
    @(posedge hclk);
    intr_vector <= 8'h5A;
    intr_req    <= 1'b1;
    wr(`CFR_OFF_FLAGS, 16'h0000);
    boundary(1'b0, 1'b0);
    wr(`CFR_OFF_FLAGS, 16'h0200);
    boundary(1'b0, 1'b1);
    chk("vector", 32'h5A, {24'h0, int_vector});
    rchk("vector_reg", `CFR_OFF_VECTOR, 16'h005A);
    wr(`CFR_OFF_FLAGS, 16'h0300);
    boundary(1'b1, 1'b0);
    intr_req <= 1'b0;
    rchk("if_kept", `CFR_OFF_FLAGS, 16'h0202);
    $display("event test done");
  endtask : t_events

  task t_string;
    wr(`CFR_OFF_FLAGS, 16'h0000);
    wr(`CFR_OFF_GPR + 8'h18, 16'h0010);
    wr(`CFR_OFF_GPR + 8'h1C, 16'h0020);
    for (int k = 0; k < 2; k++) begin
      string_word <= (k == 0);
      string_step <= 1'b1;
      @(posedge hclk);
      string_step <= 1'b0;
      rchk("src_index", `CFR_OFF_GPR + 8'h18, k == 0 ? 16'h0012 : 16'h0011);
      rchk("dst_index", `CFR_OFF_GPR + 8'h1C, k == 0 ? 16'h0022 : 16'h0021);
      wr(`CFR_OFF_FLAGS, 16'h0400);
    end
    $display("string test done");
  endtask : t_string

  task t_hold_static;
    hold_req <= 1'b1;
    @(posedge hclk);
    #1 chk("hold_ack", 32'h1, {31'h0, hold_acknowledge});
    @(posedge hclk);
    rchk("status", `CFR_OFF_STATUS, 16'h0001);
    hold_req <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 chk("hold_release", 32'h0, {31'h0, hold_acknowledge});
    @(posedge hclk);
    wr(`CFR_OFF_GPR + 8'h14, 16'h5A5A);
    wr(`CFR_OFF_FLAGS, 16'h0C95);
    clk_run = 1'b0;
    #5001 clk_run = 1'b1;
    @(negedge hclk) clk_run = 1'b0;
    #3001 clk_run = 1'b1;
    @(posedge hclk);
    rchk("held_gpr", `CFR_OFF_GPR + 8'h14, 16'h5A5A);
    rchk("held_flags", `CFR_OFF_FLAGS, 16'h0C97);
    $display("hold and static test done");
  endtask : t_hold_static

  initial begin
    hclk = 1'b0;
    clk_run = 1'b1;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    instr_done = 1'b0;
    intr_req = 1'b0;
    intr_vector = 8'h00;
    string_step = 1'b0;
    string_word = 1'b0;
    hold_req = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("flags_reset", `CFR_OFF_FLAGS, `CFR_FLAGS_RESET);
    rchk("gpr_reset", `CFR_OFF_GPR, `CFR_WORD_RESET);
    t_regs();
    t_alu();
    t_events();
    t_string();
    t_hold_static();
    complete_run();
  end
endmodule : tb_top
